// File: verilog/espsw_pkg.sv
// Constants and types for the excitation positive-node switch register block
// What this block does
// - Control register at 0x0000_2158, resets to zero: all switches open.
// - Every positive-node switch has its own independent control bit.
// - A control bit of 1 closes its switch; 0 leaves it open.
// - Bit 13 closes the output-to-positive-node short switch A.
// - Bit 10 connects the positive node to the counter electrode pin.
// - Bit 8 connects the positive node to front-end pin three.
// - Bit 7 connects the positive node to the drive electrode pin.
// - Bit 6 connects the positive node to the sense electrode pin.
// - Bit 5 connects the positive node to front-end pin two.
// - Bit 4 connects the positive node to the reference electrode pin.
// - Bit 3 connects the positive node to analog input three.
// - Bit 2 connects the positive node to analog input two.
// - Bit 1 connects the positive node to analog input one.
// - Bit 0 connects the positive node to the calibration resistor pin.
package espsw_pkg;

	////////////////////////////////////////////////////////////////////////
	// Bus and register map
	localparam int unsigned DATA_W = 32;
	localparam logic [31:0] POS_SWITCH_CTRL_OFFSET = 32'h0000_2158;
	localparam logic [31:0] POS_SWITCH_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] POS_SWITCH_CTRL_WMASK = 32'h0000_7FFF;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned BIT_SHORT_B = 14;
	localparam int unsigned BIT_SHORT_A = 13;
	localparam int unsigned BIT_COUNTER_EL = 10;
	localparam int unsigned BIT_FE_PIN_THREE = 8;
	localparam int unsigned BIT_DRIVE_EL = 7;
	localparam int unsigned BIT_SENSE_EL = 6;
	localparam int unsigned BIT_FE_PIN_TWO = 5;
	localparam int unsigned BIT_REFERENCE_EL = 4;
	localparam int unsigned BIT_AIN_THREE = 3;
	localparam int unsigned BIT_AIN_TWO = 2;
	localparam int unsigned BIT_AIN_ONE = 1;
	localparam int unsigned BIT_CAL_RES = 0;

	////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;
	} espsw_aphase_t;

	typedef struct packed {
		logic outputShortSwitchB;
		logic outputShortSwitchA;
		logic posToCounterElectrode;
		logic posToFrontendPinThree;
		logic posToDriveElectrode;
		logic posToSenseElectrode;
		logic posToFrontendPinTwo;
		logic posToReferenceElectrode;
		logic posToAnalogInputThree;
		logic posToAnalogInputTwo;
		logic posToAnalogInputOne;
		logic posToCalibrationResistor;
	} espsw_switch_t;

endpackage

// File: verilog/espsw_ctrl_reg.sv
// Storage of the positive-node switch control word
`timescale 1ns/10ps
module espsw_ctrl_reg
	import espsw_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// Write port
	input  wire logic              wrEn,
	input  wire logic [DATA_W-1:0] wrData,
	// Stored value
	output logic      [DATA_W-1:0] ctrlValue
);

	////////////////////////////////////////////////////////////////////////
	// One flop per implemented bit
	genvar i;
	generate
		for (i = 0; i < DATA_W; i++)
		begin : gBit
			if (POS_SWITCH_CTRL_WMASK[i])
			begin : gStore
				logic bit_reg;
				always_ff @(posedge clk)
				begin
					if (sys_rst)
						bit_reg <= POS_SWITCH_CTRL_RESET[i];
					else if (wrEn)
						bit_reg <= wrData[i];
				end
				assign ctrlValue[i] = bit_reg;
			end
			else
			begin : gZero
				assign ctrlValue[i] = POS_SWITCH_CTRL_RESET[i];
			end
		end
	endgenerate

endmodule

// File: verilog/espsw_ahb_slave.sv
// AHB-Lite address and data phase tracking for one register
`timescale 1ns/10ps
module espsw_ahb_slave
	import espsw_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Address phase inputs
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	// Decoded phases
	output logic             addrAccept,
	output espsw_aphase_t    dataPhase
);

	////////////////////////////////////////////////////////////////////////
	// Address phase acceptance
	wire transActive = (htrans == HTRANS_NONSEQ) || (htrans == HTRANS_SEQ);
	wire wordSized   = (hsize == HSIZE_WORD);
	assign addrAccept = hsel && hready && transActive;

	espsw_aphase_t dataPhase_reg;
	espsw_aphase_t dataPhase_next;

	always_comb
	begin
		dataPhase_next = dataPhase_reg;
		if (hready)
		begin
			dataPhase_next.valid = addrAccept && wordSized;
			dataPhase_next.write = hwrite;
			dataPhase_next.addr  = haddr;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			dataPhase_reg <= '0;
		else
			dataPhase_reg <= dataPhase_next;
	end

	assign dataPhase = dataPhase_reg;

endmodule

// File: verilog/espsw_top.sv
// Excitation positive-node switch register with AHB-Lite access
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
module espsw_top
	import espsw_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [DATA_W-1:0] hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic      [DATA_W-1:0] hrdata,
	// Switch matrix controls
	output espsw_switch_t          positiveNodeSwitches
);

	////////////////////////////////////////////////////////////////////////
	// Bus front end
	logic          addrAccept;
	espsw_aphase_t dataPhase;
	logic [DATA_W-1:0] ctrlValue;

	espsw_ahb_slave uSlave (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.hsel       (hsel),
		.haddr      (haddr),
		.htrans     (htrans),
		.hwrite     (hwrite),
		.hsize      (hsize),
		.hready     (hready),
		.addrAccept (addrAccept),
		.dataPhase  (dataPhase)
	);

	////////////////////////////////////////////////////////////////////////
	// Address decode and write commit
	// register decoded at its offset
	wire hitData = dataPhase.addr == POS_SWITCH_CTRL_OFFSET;
	wire hitAddr = haddr == POS_SWITCH_CTRL_OFFSET;
	wire wrEn    = dataPhase.valid && dataPhase.write && hitData;
	wire [DATA_W-1:0] wrMasked = hwdata & POS_SWITCH_CTRL_WMASK;

	espsw_ctrl_reg uCtrl (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.wrEn      (wrEn),
		.wrData    (wrMasked),
		.ctrlValue (ctrlValue)
	);

	////////////////////////////////////////////////////////////////////////
	// Read data, forwarded from a write committing at the same edge
	wire [DATA_W-1:0] curValue = wrEn ? wrMasked : ctrlValue;
	wire readHit = addrAccept && !hwrite && (hsize == HSIZE_WORD) && hitAddr;
	wire [DATA_W-1:0] readValue = readHit ? curValue : READ_UNMAPPED;

	logic [DATA_W-1:0] hrdata_reg;
	logic              hreadyout_reg;
	logic              hresp_reg;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			hrdata_reg    <= READ_UNMAPPED;
			hreadyout_reg <= 1'b0;
			hresp_reg     <= HRESP_OKAY;
		end
		else
		begin
			hreadyout_reg <= 1'b1;
			hresp_reg     <= HRESP_OKAY;
			if (addrAccept)
				hrdata_reg <= readValue;
		end
	end

	assign hrdata    = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp     = hresp_reg;

	////////////////////////////////////////////////////////////////////////
	// Switch drive, 1 closes and 0 opens
	// bit value is switch state
	assign positiveNodeSwitches.outputShortSwitchB = ctrlValue[BIT_SHORT_B];
	assign positiveNodeSwitches.outputShortSwitchA = ctrlValue[BIT_SHORT_A];
	assign positiveNodeSwitches.posToCounterElectrode = ctrlValue[BIT_COUNTER_EL];
	assign positiveNodeSwitches.posToFrontendPinThree = ctrlValue[BIT_FE_PIN_THREE];
	assign positiveNodeSwitches.posToDriveElectrode = ctrlValue[BIT_DRIVE_EL];
	assign positiveNodeSwitches.posToSenseElectrode = ctrlValue[BIT_SENSE_EL];
	assign positiveNodeSwitches.posToFrontendPinTwo = ctrlValue[BIT_FE_PIN_TWO];
	assign positiveNodeSwitches.posToReferenceElectrode = ctrlValue[BIT_REFERENCE_EL];
	assign positiveNodeSwitches.posToAnalogInputThree = ctrlValue[BIT_AIN_THREE];
	assign positiveNodeSwitches.posToAnalogInputTwo = ctrlValue[BIT_AIN_TWO];
	assign positiveNodeSwitches.posToAnalogInputOne = ctrlValue[BIT_AIN_ONE];
	assign positiveNodeSwitches.posToCalibrationResistor = ctrlValue[BIT_CAL_RES];

	// bits 12, 11, 9 stored only, no switch output

endmodule

// File: test/espsw_top_sva.sv
// Assertion checker for the positive-node switch register
`timescale 1ns/10ps
module espsw_sva
	import espsw_pkg::*;
(
	// Clock and reset
	input wire logic          clk,
	input wire logic          sys_rst,
	// Bus
	input wire logic          hsel,
	input wire logic [31:0]   haddr,
	input wire logic [1:0]    htrans,
	input wire logic          hwrite,
	input wire logic [2:0]    hsize,
	input wire logic [31:0]   hwdata,
	input wire logic          hready,
	input wire logic [31:0]   hrdata,
	// Switches
	input wire espsw_switch_t positiveNodeSwitches
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire        reqSeen = hsel && hready && htrans[1];
	wire        regHit  = reqSeen && hsize == 3'h2 && haddr == 32'h0000_2158;
	wire [11:0] swIn    = {hwdata[14:13], hwdata[10], hwdata[8:0]};
	logic        wrPend_reg;
	logic [31:0] shadow_reg;
	always_ff @(posedge clk)
	begin
		wrPend_reg <= !sys_rst && regHit && hwrite;
		shadow_reg <= sys_rst ? 32'h0000_0000 : (wrPend_reg ? (hwdata & 32'h0000_7FFF) : shadow_reg);
	end
	////////////////////////////////////////////////////////////////
	property p_rst; disable iff (1'b0) sys_rst |=> positiveNodeSwitches == 12'h000; endproperty
	property p_wr; wrPend_reg |=> positiveNodeSwitches == $past(swIn); endproperty
	property p_hold; !wrPend_reg |=> $stable(positiveNodeSwitches); endproperty
	property p_rd; regHit && !hwrite |=> hrdata == shadow_reg; endproperty
	property p_unm; reqSeen && !hwrite && haddr != 32'h0000_2158 |=> hrdata == 32'h0000_0000; endproperty
	property p_rsvd; hrdata[31:15] == 17'h0_0000; endproperty
	property p_sha; wrPend_reg |=> positiveNodeSwitches.outputShortSwitchA == $past(hwdata[13]); endproperty
	property p_shb; wrPend_reg |=> positiveNodeSwitches.outputShortSwitchB == $past(hwdata[14]); endproperty
	a_rst: assert property (p_rst) else $error("switches not cleared");
	a_wr: assert property (p_wr) else $error("switches differ from write");
	a_hold: assert property (p_hold) else $error("switches moved");
	a_rd: assert property (p_rd) else $error("bad readback");
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	a_rsvd: assert property (p_rsvd) else $error("upper bits set");
	a_sha: assert property (p_sha) else $error("short switch A wrong");
	a_shb: assert property (p_shb) else $error("short switch B wrong");
	c_wr: cover property (wrPend_reg && hwdata[14]);
	c_rd: cover property (regHit && !hwrite);
	c_unm: cover property (reqSeen && haddr != 32'h0000_2158);
endmodule
bind espsw_top espsw_sva chk (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
	.hrdata, .positiveNodeSwitches);

// File: test/tb_top.sv
// Self-checking bench for the positive-node switch register
`timescale 1ns/10ps
module tb_top import espsw_pkg::*;;
	localparam logic [31:0] REG_ADDR = 32'h0000_2158;
	logic          clk = 1'b0;
	logic          sys_rst = 1'b1;
	logic          hsel = 1'b0;
	logic          hwrite = 1'b0;
	logic [1:0]    htrans = 2'h0;
	logic [2:0]    hsize = 3'h2;
	logic [31:0]   haddr = 32'h0000_0000;
	logic [31:0]   hwdata = 32'h0000_0000;
	logic [31:0]   rdVal;
	logic          hreadyout;
	logic          hresp;
	logic [31:0]   hrdata;
	espsw_switch_t positiveNodeSwitches;
	int            miscompares = 0;
	int            nTests = 0;
	int            cycles = 0;
	espsw_top dut (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hreadyout, .hresp, .hrdata, .positiveNodeSwitches);
	initial forever #25 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		if (miscompares == 0 && nTests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] expV, input logic [31:0] gotV);
		nTests++;
		if (gotV !== expV)
		begin
			$display("[ERR] %s expected %h seen %h", what, expV, gotV);
			miscompares++;
		end
	endtask
	function automatic logic [31:0] swOf(input logic [31:0] v);
		return {20'h0_0000, v[14:13], v[10], v[8:0]};
	endfunction
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= sz;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= HTRANS_IDLE;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdVal = hrdata;
		check("hresp", 32'h0000_0000, {31'h0, hresp});
	endtask
	task automatic put_and_verify(input logic [31:0] v);
		xfer(1'b1, REG_ADDR, v, HSIZE_WORD);
		xfer(1'b0, REG_ADDR, 32'h0000_0000, HSIZE_WORD);
		check("readback", v & 32'h0000_7FFF, rdVal);
		check("switches", swOf(v), {20'h0_0000, positiveNodeSwitches});
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_walk();
		for (int i = 0; i < 15; i++)
			put_and_verify(32'h0000_0001 << i);
	endtask
	task automatic t_patterns();
		put_and_verify(32'hFFFF_FFFF);
		put_and_verify(32'hFFFF_8000);
		put_and_verify(32'h0000_5555);
		put_and_verify(32'h0000_2AAA);
	endtask
	task automatic t_refused();
		put_and_verify(32'h0000_0155);
		xfer(1'b1, REG_ADDR + 32'h0000_0004, 32'hFFFF_FFFF, HSIZE_WORD);
		xfer(1'b1, REG_ADDR, 32'hFFFF_FFFF, 3'h0);
		xfer(1'b0, REG_ADDR + 32'h0000_0004, 32'h0000_0000, HSIZE_WORD);
		check("unmapped read", 32'h0000_0000, rdVal);
		xfer(1'b0, REG_ADDR, 32'h0000_0000, HSIZE_WORD);
		check("after refused", 32'h0000_0155, rdVal);
	endtask
	task automatic t_reset(input logic pulse);
		if (pulse)
		begin
			xfer(1'b1, REG_ADDR, 32'h0000_6400, HSIZE_WORD);
			@(posedge clk);
			check("pre-reset switches", swOf(32'h0000_6400), {20'h0_0000, positiveNodeSwitches});
			sys_rst <= 1'b1;
			@(posedge clk);
			sys_rst <= 1'b0;
			repeat (2) @(posedge clk);
		end
		check("reset switches", 32'h0000_0000, {20'h0_0000, positiveNodeSwitches});
		xfer(1'b0, REG_ADDR, 32'h0000_0000, HSIZE_WORD);
		check("reset value", 32'h0000_0000, rdVal);
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset(1'b0);
		t_walk();
		t_patterns();
		t_refused();
		t_reset(1'b1);
		tally_and_finish();
	end
endmodule
